//--- design/tli_table_lookup_interpolate_unit.v
// table lookup and linear interpolate datapath
// Operation
// - signed rounded lookup gives signed rounded result of byte, word or long size
// - signed unrounded lookup gives signed result keeping the fraction
// - unsigned rounded lookup treats entries unsigned, rounds to integer
// - unsigned unrounded lookup treats entries unsigned, no rounding
// - endpoints come from a memory table or a data register pair
// - table form: variable bits 15..8 are entry offset, 7..0 fraction
// - result is entry plus fraction times difference over 256
// - rounded variants round to nearest even
// - unrounded variants return result with eight fraction bits
// - register form: fraction from destination, endpoints from register pair
`include "tli_consts.vh"
module tli_table_lookup_interpolate_unit #(
    parameter AW = 32
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          start,
    input  wire          isSigned,
    input  wire          isRounded,
    input  wire [1:0]    opSize,
    input  wire          useRegPair,
    input  wire [31:0]   independentVariable,
    input  wire [31:0]   fractionDestination,
    input  wire [31:0]   pairFirst,
    input  wire [31:0]   pairSecond,
    input  wire [AW-1:0] effectiveAddress,
    output reg           memRead,
    output reg  [AW-1:0] memAddr,
    input  wire          memAck,
    input  wire [31:0]   memData,
    output reg           busy,
    output reg           done,
    output reg  [31:0]   result
);
    // nine spare bits above a sign-extended long keep the difference exact
    localparam DATA_W = 32;
    localparam EXT_W  = 41;
    localparam FRAC_W = `TLI_FRAC_BITS;
    localparam OFS_W  = `TLI_OFS_HI - `TLI_OFS_LO + 1;
    localparam PROD_W = EXT_W + FRAC_W + 1;
    localparam RND_W  = PROD_W - FRAC_W;

    // controller states
    localparam ST_IDLE   = `TLI_ST_IDLE;
    localparam ST_FETCH0 = `TLI_ST_FETCH0;
    localparam ST_FETCH1 = `TLI_ST_FETCH1;
    localparam ST_CALC   = `TLI_ST_CALC;

    reg  [1:0]          state;
    reg  [1:0]          next_state;
    reg                 sgn;
    reg                 rnd;
    reg  [1:0]          sz;
    reg  [FRAC_W-1:0]   frac;
    reg  [DATA_W-1:0]   entryA;
    reg  [DATA_W-1:0]   entryB;
    reg  [1:0]          reqSize;
    reg  [4:0]          msbIdx;

    // control strobes
    wire                takeStart;
    wire                ackFirst;
    wire                ackSecond;
    wire                finishOp;

    // endpoint extension
    wire                signA;
    wire                signB;
    wire [EXT_W-1:0]    a41;
    wire [EXT_W-1:0]    b41;

    // interpolation arithmetic
    wire [EXT_W-1:0]    diff;
    wire [PROD_W-1:0]   diffX;
    wire [PROD_W-1:0]   fracX;
    wire [PROD_W-1:0]   prod;
    wire [PROD_W-1:0]   baseX;
    wire [PROD_W-1:0]   scaled;

    // rounding
    wire                guardBit;
    wire                stickyBit;
    wire                evenBit;
    wire                roundUp;
    wire [RND_W-1:0]    rounded;
    wire [DATA_W-1:0]   rndOut;
    wire [DATA_W-1:0]   rawOut;

    // address generation
    wire [AW-1:0]       ofs;
    wire [AW-1:0]       ofsScaled;
    wire [AW-1:0]       addr0;
    wire [AW-1:0]       step;

    // spare size code behaves as long so address steps stay within a long
    always @* begin
        case (opSize)
            `TLI_SIZE_BYTE: reqSize = `TLI_SIZE_BYTE;
            `TLI_SIZE_WORD: reqSize = `TLI_SIZE_WORD;
            default:        reqSize = `TLI_SIZE_LONG;
        endcase
    end

    assign takeStart = (state == ST_IDLE) & start;
    assign ackFirst  = (state == ST_FETCH0) & memAck;
    assign ackSecond = (state == ST_FETCH1) & memAck;
    assign finishOp  = (state == ST_CALC);

    // top bit of the operand size in use
    always @* begin
        case (sz)
            `TLI_SIZE_BYTE: msbIdx = `TLI_BYTE_MSB;
            `TLI_SIZE_WORD: msbIdx = `TLI_WORD_MSB;
            default:        msbIdx = `TLI_LONG_MSB;
        endcase
    end

    assign signA = sgn & entryA[msbIdx];
    assign signB = sgn & entryB[msbIdx];

    genvar gi;
    generate
        for (gi = 0; gi < EXT_W; gi = gi + 1) begin : g_ext
            if (gi < DATA_W) begin : g_data
                assign a41[gi] = (gi <= msbIdx) ? entryA[gi] : signA;
                assign b41[gi] = (gi <= msbIdx) ? entryB[gi] : signB;
            end else begin : g_sign
                assign a41[gi] = signA;
                assign b41[gi] = signB;
            end
        end
    endgenerate

    // fraction times difference, kept modulo the product width
    assign diff   = b41 - a41;
    assign diffX  = {{(PROD_W-EXT_W){diff[EXT_W-1]}}, diff};
    assign fracX  = {{(PROD_W-FRAC_W){1'b0}}, frac};
    assign prod   = diffX * fracX;
    assign baseX  = {{(PROD_W-EXT_W-FRAC_W){a41[EXT_W-1]}}, a41, {FRAC_W{1'b0}}};
    assign scaled = baseX + prod;

    // round to nearest even on the dropped fraction
    assign guardBit  = scaled[FRAC_W-1];
    assign stickyBit = |scaled[FRAC_W-2:0];
    assign evenBit   = scaled[FRAC_W];
    assign roundUp   = guardBit & (stickyBit | evenBit);
    assign rounded   = scaled[PROD_W-1:FRAC_W] +
                       {{(RND_W-1){1'b0}}, roundUp};
    assign rndOut    = rounded[DATA_W-1:0];
    assign rawOut    = scaled[DATA_W-1:0];

    // entry offset scaled by operand size
    assign ofs       = {{(AW-OFS_W){1'b0}}, independentVariable[`TLI_OFS_HI:`TLI_OFS_LO]};
    assign ofsScaled = ofs << reqSize;
    assign addr0     = effectiveAddress + ofsScaled;
    assign step      = {{(AW-1){1'b0}}, 1'b1} << sz;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = useRegPair ? ST_CALC : ST_FETCH0;
                end
            end
            ST_FETCH0: begin
                if (memAck) begin
                    next_state = ST_FETCH1;
                end
            end
            ST_FETCH1: begin
                if (memAck) begin
                    next_state = ST_CALC;
                end
            end
            ST_CALC: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // variant and size held for the whole operation
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sgn <= 1'b0;
        end else if (takeStart) begin
            sgn <= isSigned;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rnd <= 1'b0;
        end else if (takeStart) begin
            rnd <= isRounded;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sz <= `TLI_SIZE_BYTE;
        end else if (takeStart) begin
            sz <= reqSize;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frac <= `TLI_ZERO_FRAC;
        end else if (takeStart) begin
            if (useRegPair) begin
                frac <= fractionDestination[`TLI_FRAC_HI:`TLI_FRAC_LO];
            end else begin
                frac <= independentVariable[`TLI_FRAC_HI:`TLI_FRAC_LO];
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            entryA <= `TLI_ZERO_WORD;
        end else if (takeStart && useRegPair) begin
            entryA <= pairFirst;
        end else if (ackFirst) begin
            entryA <= memData;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            entryB <= `TLI_ZERO_WORD;
        end else if (takeStart && useRegPair) begin
            entryB <= pairSecond;
        end else if (ackSecond) begin
            entryB <= memData;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memRead <= 1'b0;
        end else if (takeStart && !useRegPair) begin
            memRead <= 1'b1;
        end else if (ackSecond) begin
            memRead <= 1'b0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memAddr <= {AW{1'b0}};
        end else if (takeStart && !useRegPair) begin
            memAddr <= addr0;
        end else if (ackFirst) begin
            memAddr <= memAddr + step;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (takeStart) begin
            busy <= 1'b1;
        end else if (finishOp) begin
            busy <= 1'b0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else if (finishOp) begin
            done <= 1'b1;
        end else begin
            done <= 1'b0;
        end
    end

    // result holds until the next operation completes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= `TLI_ZERO_WORD;
        end else if (finishOp) begin
            result <= rnd ? rndOut : rawOut;
        end
    end
endmodule

//--- design/tli_consts.vh
// constants for the table lookup and interpolate unit
`ifndef TLI_CONSTS_VH
`define TLI_CONSTS_VH
`define TLI_SIZE_BYTE   2'h0
`define TLI_SIZE_WORD   2'h1
`define TLI_SIZE_LONG   2'h2
`define TLI_SIZE_SPARE  2'h3
`define TLI_BYTE_MSB    5'h07
`define TLI_WORD_MSB    5'h0F
`define TLI_LONG_MSB    5'h1F
`define TLI_ZERO_WORD   32'h0000_0000
`define TLI_ZERO_FRAC   8'h00
`define TLI_OFS_HI      15
`define TLI_OFS_LO      8
`define TLI_FRAC_HI     7
`define TLI_FRAC_LO     0
`define TLI_FRAC_BITS   8
`define TLI_ST_IDLE     2'h0
`define TLI_ST_FETCH0   2'h1
`define TLI_ST_FETCH1   2'h2
`define TLI_ST_CALC     2'h3
`endif

//--- testbench/tli_checker.sv
// assertion checker for the table lookup interpolate unit
module tli_checker (
    input logic        clk, rst_n, start, busy, done, useRegPair, memRead, memAck,
    input logic [1:0]  opSize,
    input logic [31:0] independentVariable, effectiveAddress, memAddr, result
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [1:0] sz;
    // size is captured only when a start is really taken
    always @(posedge clk) if (start && !busy) sz <= (opSize == 2'h3) ? 2'h2 : opSize;
    sequence s_go; start && !busy; endsequence
    sequence s_ack; memRead && memAck; endsequence
    a_pair_done: assert property (s_go ##0 useRegPair |-> ##2 done)
        else $error("pair late");
    a_table_done: assert property (s_ack ##1 !memRead |=> done)
        else $error("table late");
    a_first_addr: assert property (s_go ##0 !useRegPair |=> memRead && memAddr ==
        $past(effectiveAddress) + ($past(independentVariable[15:8]) << sz))
        else $error("first address");
    a_next_addr: assert property (s_ack ##1 memRead |->
        memAddr == $past(memAddr) + (32'h0000_0001 << sz))
        else $error("next address");
    a_addr_hold: assert property (memRead && !memAck |=> memRead && $stable(memAddr))
        else $error("address moved");
    a_busy_run: assert property (s_go |=> busy)
        else $error("busy missing");
    a_done_pulse: assert property (done |=> !done)
        else $error("done long");
    a_done_idle: assert property (done |-> !busy)
        else $error("busy at done");
    a_result_hold: assert property (!done |-> $stable(result))
        else $error("result moved");
endmodule
bind tli_table_lookup_interpolate_unit tli_checker u_chk (.clk, .rst_n, .start, .busy, .done,
    .useRegPair, .memRead, .memAck, .opSize, .independentVariable, .effectiveAddress,
    .memAddr, .result);

//--- testbench/tli_table_lookup_interpolate_unit_tb.sv
// self-checking bench for the table lookup interpolate unit
module tli_table_lookup_interpolate_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, start = 0, isSigned = 0, isRounded = 0, useRegPair = 0;
    logic        memAck = 0, memRead, busy, done;
    logic [1:0]  opSize = 0;
    logic [31:0] independentVariable = 0, fractionDestination = 0, pairFirst = 0;
    logic [31:0] pairSecond = 0, memData = 0, memAddr, result;
    int          miscompares = 0, n_checks = 0;
    always #20 clk = ~clk;
    tli_table_lookup_interpolate_unit u_dut (.clk, .rst_n, .start, .isSigned, .isRounded,
        .opSize, .useRegPair, .independentVariable, .fractionDestination, .pairFirst,
        .pairSecond, .effectiveAddress(32'h0000_1000), .memRead, .memAddr, .memAck,
        .memData, .busy, .done, .result);
    // bench answers fetches as memory: first entry, then the next one
    task automatic op(input logic sg, rd, pr, input logic [1:0] sz,
                      input logic [31:0] iv, a, b, ex);
        int   n;
        logic ak;
        n = 0;
        @(posedge clk);
        {start, isSigned, isRounded, useRegPair, opSize} <= {1'b1, sg, rd, pr, sz};
        {independentVariable, fractionDestination, pairFirst, pairSecond} <= {iv, iv, a, b};
        @(posedge clk) start <= 0;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            if (done === 1'b1) break;
            ak = memRead === 1'b1 && memAck !== 1'b1;
            @(posedge clk);
            memAck <= ak;
            memData <= n ? b : a;
            n += ak;
        end
        n_checks++;
        if (done !== 1'b1 || result !== ex) begin
            miscompares++;
            $display("Error %0t: result %h, expected %h", $time, result, ex);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_table;
        op(0, 1, 0, 2'h1, 32'h0000_A380, 32'h0000_0685,
           32'h0000_068F, 32'h0000_068A);
        // upper data bits are junk, byte size must ignore them
        op(0, 0, 0, 2'h0, 32'h0000_0140, 32'h1234_56F0,
           32'h55AA_AA10, 32'h0000_B800);
        // signed long entries, a non-tie fraction rounds up
        op(1, 1, 0, 2'h2, 32'h0000_05C0, 32'hFFFF_FF00,
           32'h0000_0101, 32'h0000_0081);
        $display("table form done");
    endtask
    task automatic t_pair;
        // both halfway ties go to the even integer
        op(1, 1, 1, 2'h0, 32'h0000_0080, 32'h0000_0001, 32'h0000_0002, 32'h0000_0002);
        op(1, 1, 1, 2'h0, 32'h0000_0080, 32'h0000_0002, 32'h0000_0003, 32'h0000_0002);
        op(1, 0, 1, 2'h0, 32'h0000_0040, 32'h0000_00F0,
           32'h0000_0010, 32'hFFFF_F800);
        // surface step: word rounded over two byte unrounded results
        op(1, 1, 1, 2'h1, 32'h0000_0080, 32'h0000_0180,
           32'hFFFF_F800, 32'hFFFF_FCC0);
        $display("pair form done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        t_table();
        t_pair();
        close_out();
    end
    initial begin
        #20us;
        miscompares++;
        close_out();
    end
endmodule
